// *** pkg/mbpwm_pkg.sv ***
// Function
// - 32-bit counter stepped by 32-bit prescaler
// - Seven matches feed six outputs; outputs 2 to 6 can be double-edge
// - Period match restarts the count in PWM mode
// - Single-edge outputs rise at cycle start
// - One match places each single-edge fall
// - Two matches place double-edge rise and fall
// - All outputs share one period
// - Period and width take any count
// - Per match: continue, stop or reset, interrupt
// - Released match values apply at cycle start
// - Without PWM mode: plain timer, outputs low
// - All match events with the interrupt action form one interrupt
package mbpwm_pkg;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned NUM_MATCH = 7;
  localparam int unsigned NUM_OUT = 6;
  // Word indices; byte offset is four times the index
  localparam logic [5:0] IDX_FLAGS = 6'h00;
  localparam logic [5:0] IDX_CTRL = 6'h01;
  localparam logic [5:0] IDX_TC = 6'h02;
  localparam logic [5:0] IDX_PLIM = 6'h03;
  localparam logic [5:0] IDX_PCNT = 6'h04;
  localparam logic [5:0] IDX_MCTL = 6'h05;
  localparam logic [5:0] IDX_MR0 = 6'h06;
  localparam logic [5:0] IDX_OCTL = 6'h0d;
  localparam logic [5:0] IDX_LATCH = 6'h0e;
  localparam logic [5:0] IDX_NONE = 6'h3f;
  // Control register fields
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_CRST = 1;
  localparam int unsigned CTRL_PWM = 3;
  // Match control: three bits per match
  localparam int unsigned MCTL_INT = 0;
  localparam int unsigned MCTL_RST = 1;
  localparam int unsigned MCTL_STOP = 2;
  localparam int unsigned MCTL_STRIDE = 3;
  localparam int unsigned MCTL_W = 21;
  // Output control: select bits 2..6, enables 9..14
  localparam int unsigned OCTL_EN_LSB = 9;
  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } mbpwm_bus_e;
endpackage

// *** verilog/mbpwm_prescaler.sv ***
`timescale 1ns/100ps
module mbpwm_prescaler #(
  parameter int unsigned W = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [W-1:0] limit_i,
  output logic tick_o,
  output logic [W-1:0] count_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } mbpwm_presc_s;

  mbpwm_presc_s r;
  mbpwm_presc_s n;
  logic at_lim;

  // Compare with >= so a lowered limit never waits a full wrap
  assign at_lim = (r.cnt >= limit_i);
  assign tick_o = run_i && !clear_i && at_lim;
  assign count_o = r.cnt;

  // Next prescale count
  always_comb begin
    n = r;
    if (clear_i) begin
      n.cnt = '0;
    end else if (run_i) begin
      n.cnt = at_lim ? '0 : r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_wrap;
    tick_o |=> count_o == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("prescaler did not wrap");

  property p_step;
    run_i && !clear_i && (count_o < limit_i) |=> count_o == $past(count_o) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("prescaler did not step");
endmodule

// *** verilog/mbpwm_top.sv ***
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module mbpwm_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  output logic [mbpwm_pkg::NUM_OUT-1:0] pwm_o,
  output logic irq_o
);
  import mbpwm_pkg::*;

  typedef struct packed {
    mbpwm_bus_e bus;
    logic rdy;
    logic resp;
    logic [31:0] rdata;
    logic wr;
    logic [5:0] widx;
    logic [5:0] ridx;
    logic run;
    logic crst;
    logic pwm_en;
    logic [CNT_W-1:0] tc;
    logic [CNT_W-1:0] plim;
    logic [MCTL_W-1:0] mctl;
    logic [NUM_MATCH-1:0][CNT_W-1:0] mr_w;
    logic [NUM_MATCH-1:0][CNT_W-1:0] mr_a;
    logic [NUM_MATCH-1:0] sel;
    logic [NUM_OUT-1:0] oen;
    logic [NUM_MATCH-1:0] ler;
    logic [NUM_MATCH-1:0] flags;
    logic [NUM_OUT-1:0] pwm;
    logic irq;
  } mbpwm_state_s;

  mbpwm_state_s r;
  mbpwm_state_s n;
  logic tick;
  logic [CNT_W-1:0] pcnt;
  logic [NUM_MATCH-1:0] match;
  logic cs;
  logic rst_hit;
  logic stop_hit;
  logic acc;
  logic [5:0] aidx;
  logic [NUM_MATCH-1:0] fset;
  logic [NUM_MATCH-1:0] fclr;
  logic [NUM_MATCH-1:0] lset;
  logic up_v;
  logic dn_v;

  // True when a word index falls on a match value
  function automatic logic is_mr(logic [5:0] idx);
    return (idx >= IDX_MR0) && (idx < IDX_MR0 + 6'(NUM_MATCH));
  endfunction

  // Match slot addressed by a word index
  function automatic logic [2:0] mr_num(logic [5:0] idx);
    logic [5:0] d;
    d = idx - IDX_MR0;
    return d[2:0];
  endfunction

  // One action bit of one match
  function automatic logic mctl_bit(logic [MCTL_W-1:0] m, int i, int k);
    return m[i * MCTL_STRIDE + k];
  endfunction

  // Read mux; unmapped words read as zero
  function automatic logic [31:0] read_word(mbpwm_state_s s, logic [CNT_W-1:0] pc,
                                            logic [5:0] idx);
    logic [31:0] v;
    v = '0;
    if (idx == IDX_FLAGS) begin
      v[NUM_MATCH-1:0] = s.flags;
    end else if (idx == IDX_CTRL) begin
      v[CTRL_RUN] = s.run;
      v[CTRL_CRST] = s.crst;
      v[CTRL_PWM] = s.pwm_en;
    end else if (idx == IDX_TC) begin
      v = s.tc;
    end else if (idx == IDX_PLIM) begin
      v = s.plim;
    end else if (idx == IDX_PCNT) begin
      v = pc;
    end else if (idx == IDX_MCTL) begin
      v[MCTL_W-1:0] = s.mctl;
    end else if (is_mr(idx)) begin
      v = s.mr_w[mr_num(idx)];
    end else if (idx == IDX_OCTL) begin
      v[NUM_MATCH-1:0] = s.sel;
      v[OCTL_EN_LSB +: NUM_OUT] = s.oen;
    end else if (idx == IDX_LATCH) begin
      v[NUM_MATCH-1:0] = s.ler;
    end
    return v;
  endfunction

  // Prescaler sets how many clocks make one count step
  mbpwm_prescaler #(
    .W(CNT_W)
  ) u_presc (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .run_i(r.run),
    .clear_i(r.crst),
    .limit_i(r.plim),
    .tick_o(tick),
    .count_o(pcnt)
  );

  // Address phase decode; words above the block alias to nothing
  assign acc = hsel_i && hready_i && htrans_i[1];
  assign aidx = (|haddr_i[31:8]) ? IDX_NONE : haddr_i[7:2];

  // Match events, one per count step
  always_comb begin
    match = '0;
    for (int i = 0; i < NUM_MATCH; i++) begin
      match[i] = tick && (r.tc == r.mr_a[i]);
    end
  end

  // Cycle start only exists in PWM mode
  assign cs = r.pwm_en && match[0];

  // Gather actions of all matching registers
  always_comb begin
    rst_hit = cs;
    stop_hit = 1'b0;
    fset = '0;
    for (int i = 0; i < NUM_MATCH; i++) begin
      if (match[i]) begin
        rst_hit = rst_hit | mctl_bit(r.mctl, i, MCTL_RST);
        stop_hit = stop_hit | mctl_bit(r.mctl, i, MCTL_STOP);
        fset[i] = mctl_bit(r.mctl, i, MCTL_INT);
      end
    end
  end

  // Next state: bus, registers, counter, outputs
  always_comb begin
    n = r;
    n.wr = 1'b0;
    fclr = '0;
    lset = '0;
    up_v = 1'b0;
    dn_v = 1'b0;

    // Reads wait one cycle so a write just before is seen
    unique case (r.bus)
      BUS_IDLE: begin
        n.rdy = 1'b1;
        if (acc && !hwrite_i) begin
          n.bus = BUS_READ;
          n.rdy = 1'b0;
          n.ridx = aidx;
        end
        if (acc && hwrite_i) begin
          n.wr = 1'b1;
          n.widx = aidx;
        end
      end
      BUS_READ: begin
        n.bus = BUS_IDLE;
        n.rdy = 1'b1;
        n.rdata = read_word(r, pcnt, r.ridx);
      end
    endcase

    // Write data phase
    if (r.wr) begin
      if (r.widx == IDX_FLAGS) begin
        fclr = hwdata_i[NUM_MATCH-1:0];
      end
      if (r.widx == IDX_CTRL) begin
        n.run = hwdata_i[CTRL_RUN];
        n.crst = hwdata_i[CTRL_CRST];
        n.pwm_en = hwdata_i[CTRL_PWM];
      end
      if (r.widx == IDX_PLIM) begin
        n.plim = hwdata_i;
      end
      if (r.widx == IDX_MCTL) begin
        n.mctl = hwdata_i[MCTL_W-1:0];
      end
      if (r.widx == IDX_OCTL) begin
        // Outputs 1 and the period slot have no double-edge mode
        n.sel = {hwdata_i[NUM_MATCH-1:2], 2'b00};
        n.oen = hwdata_i[OCTL_EN_LSB +: NUM_OUT];
      end
      if (r.widx == IDX_LATCH) begin
        lset = hwdata_i[NUM_MATCH-1:0];
      end
      if (is_mr(r.widx)) begin
        n.mr_w[mr_num(r.widx)] = hwdata_i;
        // Timer mode takes new values at once
        if (!r.pwm_en) begin
          n.mr_a[mr_num(r.widx)] = hwdata_i;
        end
      end
    end

    // Counter: held in reset, else steps on prescaler wrap
    if (r.crst) begin
      n.tc = '0;
    end else if (tick) begin
      n.tc = rst_hit ? '0 : r.tc + 1'b1;
    end
    // A stop match overrides a run write in the same cycle
    if (stop_hit) begin
      n.run = 1'b0;
    end

    // Sticky flags; a new event beats a clear
    n.flags = (r.flags & ~fclr) | fset;
    n.irq = |n.flags;

    // Released values move to the active set at cycle start
    if (cs) begin
      for (int i = 0; i < NUM_MATCH; i++) begin
        if (r.ler[i]) begin
          n.mr_a[i] = r.mr_w[i];
        end
      end
      n.ler = '0;
    end
    n.ler = n.ler | lset;

    // Edge logic; a fall in the same step wins over a rise
    for (int k = 0; k < NUM_OUT; k++) begin
      if (r.sel[k+1]) begin
        up_v = match[k];
        dn_v = match[k+1];
      end else begin
        up_v = cs && (n.mr_a[k+1] != '0);
        dn_v = match[k+1];
      end
      if (dn_v) begin
        n.pwm[k] = 1'b0;
      end else if (up_v) begin
        n.pwm[k] = 1'b1;
      end
    end
    // All outputs share the period; disabled ones stay low
    n.pwm = n.pwm & n.oen & {NUM_OUT{n.pwm_en}};
    n.resp = 1'b0;
  end

  // State register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= '0;
      r.bus <= BUS_IDLE;
      r.rdy <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Ports straight from state flops
  assign hreadyout_o = r.rdy;
  assign hrdata_o = r.rdata;
  assign hresp_o = r.resp;
  assign pwm_o = r.pwm;
  assign irq_o = r.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_count;
    tick && !r.crst && !rst_hit |=> r.tc == $past(r.tc) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("counter did not step");

  property p_period;
    cs && !r.crst |=> r.tc == '0;
  endproperty
  a_period: assert property (p_period) else $error("period match did not restart");

  // Enable is taken from the next state, as the output mask is
  sequence s_rise1;
    cs && n.pwm_en && n.oen[0] && !match[1] && (n.mr_a[1] != '0);
  endsequence
  property p_rise1;
    s_rise1 |=> pwm_o[0];
  endproperty
  a_rise1: assert property (p_rise1) else $error("single edge output did not rise");

  property p_fall1;
    match[1] |=> !pwm_o[0];
  endproperty
  a_fall1: assert property (p_fall1) else $error("single edge output did not fall");

  // Output 4 as double-edge: rise on match 3, fall on match 4
  sequence s_dbl_up;
    n.pwm_en && n.oen[3] && r.sel[4] && match[3] && !match[4];
  endsequence
  sequence s_dbl_dn;
    r.sel[4] && match[4];
  endsequence
  property p_dbl;
    s_dbl_up |=> pwm_o[3];
  endproperty
  a_dbl: assert property (p_dbl) else $error("double edge output did not rise");
  property p_dbl_dn;
    s_dbl_dn |=> !pwm_o[3];
  endproperty
  a_dbl_dn: assert property (p_dbl_dn) else $error("double edge output did not fall");

  property p_stop;
    match[1] && mctl_bit(r.mctl, 1, MCTL_STOP) |=> !r.run;
  endproperty
  a_stop: assert property (p_stop) else $error("stop action missed");

  property p_flag;
    match[0] && mctl_bit(r.mctl, 0, MCTL_INT) |=> r.flags[0] && irq_o;
  endproperty
  a_flag: assert property (p_flag) else $error("flag or request missing");

  // A flag only drops on a software clear of its own bit
  property p_sticky;
    r.flags[0] && !(r.wr && (r.widx == IDX_FLAGS) && hwdata_i[0]) |=> r.flags[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_hold;
    r.pwm_en && !cs |=> $stable(r.mr_a);
  endproperty
  a_hold: assert property (p_hold) else $error("match value changed mid cycle");

  property p_apply;
    cs && r.ler[1] |=> r.mr_a[1] == $past(r.mr_w[1]);
  endproperty
  a_apply: assert property (p_apply) else $error("released value not applied");

  property p_nopwm;
    !r.pwm_en |-> pwm_o == '0;
  endproperty
  a_nopwm: assert property (p_nopwm) else $error("output active outside PWM mode");
endmodule

// *** dv/tb_match_based_pulse_width_modulator.sv ***
`timescale 1ns/100ps
module tb_match_based_pulse_width_modulator;
  import mbpwm_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic hreadyout_o;
  logic hresp_o;
  logic irq_o;
  logic [31:0] hrdata_o;
  logic [NUM_OUT-1:0] pwm_o;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int hi[NUM_OUT];
  int unsigned m[NUM_MATCH];
  int unsigned p, w2, i;
  logic [31:0] rd, t1, v;

  mbpwm_top uut (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o),
    .hresp_o(hresp_o), .pwm_o(pwm_o), .irq_o(irq_o));

  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard; whole run needs about a thousand cycles at most
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic wait_ready();
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
  endtask

  // One AHB single transfer; master waits as long as the slave stalls
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, idx, 2'b00};
    hwrite_i <= wr;
    wait_ready();
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    wait_ready();
    q = hrdata_o;
    check("hresp", {31'h0, hresp_o}, 32'h0);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, t1);
  endtask

  task automatic rdc(input string n, input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, rd);
    check(n, rd, exp);
  endtask

  task automatic wait_irq();
    i = 0;
    while (irq_o !== 1'b1 && i < 200) begin
      @(posedge clk_i);
      i++;
    end
  endtask

  // High cycles per period; a negative double-edge pulse wraps the period
  function automatic int unsigned exp_high(input bit dbl, input int unsigned rise, fall, per);
    if (!dbl) begin
      return (fall == 0) ? 0 : fall + 1;
    end
    return (rise < fall) ? fall - rise : per + 1 - (rise - fall);
  endfunction

  // Window of two whole periods, so the starting phase does not matter
  task automatic pwm_check(input int unsigned m1, input bit en);
    foreach (hi[k]) hi[k] = 0;
    repeat (2 * (p + 1)) begin
      @(posedge clk_i);
      foreach (hi[k]) hi[k] += (pwm_o[k] === 1'b1);
    end
    check("pwm1", hi[0], en ? 2 * exp_high(0, 0, m1, p) : 0);
    check("pwm2", hi[1], 0);
    check("pwm3", hi[2], 0);
    check("pwm4", hi[3], en ? 2 * exp_high(1, m[3], m[4], p) : 0);
    check("pwm5", hi[4], en ? 2 * exp_high(0, 0, m[5], p) : 0);
    check("pwm6", hi[5], en ? 2 * exp_high(1, m[5], m[6], p) : 0);
  endtask

  task automatic end_test(input string n);
    $display("test %s done", n);
  endtask

  // Main sequence
  initial begin
    void'($urandom(77));
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    check("ready_rst", {31'h0, hreadyout_o}, 32'h1);
    check("pwm_rst", {26'h0, pwm_o}, 32'h0);
    check("irq_rst", {31'h0, irq_o}, 32'h0);
    rdc("ctrl_rst", IDX_CTRL, 32'h0);
    rdc("tc_rst", IDX_TC, 32'h0);
    end_test("reset");
    // Random match values read back; read-only and unmapped words ignore writes
    for (int k = 0; k < NUM_MATCH; k++) begin
      v = $urandom;
      wr(6'(IDX_MR0 + k), v);
      rdc("match_rb", 6'(IDX_MR0 + k), v);
    end
    wr(IDX_TC, $urandom);
    rdc("tc_ro", IDX_TC, 32'h0);
    wr(IDX_NONE, $urandom);
    rdc("unmapped", IDX_NONE, 32'h0);
    end_test("registers");
    // Prescale limit 3: one count step every four cycles
    wr(IDX_PLIM, 32'h3);
    wr(IDX_MCTL, 32'h0);
    wr(IDX_CTRL, 32'h1);
    repeat (4) begin
      bus(1'b0, IDX_PCNT, 32'h0, rd);
      check("pcnt_max", {31'h0, rd <= 32'h3}, 32'h1);
    end
    bus(1'b0, IDX_TC, 32'h0, t1);
    repeat (40) @(posedge clk_i);
    bus(1'b0, IDX_TC, 32'h0, rd);
    check("tc_rate", rd - t1, 32'hb);
    wr(IDX_CTRL, 32'h2);
    rdc("tc_clr", IDX_TC, 32'h0);
    rdc("pcnt_clr", IDX_PCNT, 32'h0);
    end_test("prescaler");
    // Match 0 resets the count and flags an interrupt
    wr(IDX_PLIM, 32'h0);
    wr(IDX_MR0, 32'h4);
    wr(IDX_MCTL, 32'h3);
    wr(IDX_CTRL, 32'h1);
    wait_irq();
    check("irq_m0", {31'h0, irq_o}, 32'h1);
    repeat (4) begin
      bus(1'b0, IDX_TC, 32'h0, rd);
      check("tc_wrap", {31'h0, rd <= 32'h4}, 32'h1);
    end
    wr(IDX_CTRL, 32'h0);
    rdc("flag0", IDX_FLAGS, 32'h1);
    wr(IDX_FLAGS, 32'h7f);
    repeat (2) @(posedge clk_i);
    check("irq_clr", {31'h0, irq_o}, 32'h0);
    rdc("flag_clr", IDX_FLAGS, 32'h0);
    end_test("match_reset");
    // Match 1 stops the counter and flags an interrupt
    wr(IDX_MCTL, 32'h28);
    wr(IDX_MR0 + 6'h1, 32'h6);
    wr(IDX_CTRL, 32'h2);
    wr(IDX_CTRL, 32'h1);
    wait_irq();
    check("irq_m1", {31'h0, irq_o}, 32'h1);
    rdc("stop_run", IDX_CTRL, 32'h0);
    rdc("tc_stop", IDX_TC, 32'h7);
    rdc("tc_held", IDX_TC, 32'h7);
    rdc("flag1", IDX_FLAGS, 32'h2);
    wr(IDX_FLAGS, 32'h7f);
    end_test("match_stop");
    // PWM: out1 single, out2 constant low, out3 off, out4 positive, out5 single,
    // out6 negative pulse
    p = 24 + $urandom % 16;
    m[0] = p;
    m[1] = 1 + $urandom % (p - 2);
    m[2] = 0;
    m[3] = 1 + $urandom % 10;
    m[4] = m[3] + 1 + $urandom % 10;
    m[6] = 1 + $urandom % 10;
    m[5] = m[6] + 1 + $urandom % 10;
    w2 = 1 + $urandom % (p - 2);
    if (w2 == m[1]) begin
      w2 = m[1] + 1;
    end
    wr(IDX_CTRL, 32'h2);
    wr(IDX_MCTL, 32'h0);
    for (int k = 0; k < NUM_MATCH; k++) begin
      wr(6'(IDX_MR0 + k), m[k]);
    end
    wr(IDX_OCTL, 32'h7650);
    wr(IDX_CTRL, 32'h9);
    repeat (3 * (p + 1)) @(posedge clk_i);
    pwm_check(m[1], 1'b1);
    end_test("pwm");
    // New width stays inactive until released
    wr(IDX_MR0 + 6'h1, w2);
    repeat (2 * (p + 1)) @(posedge clk_i);
    pwm_check(m[1], 1'b1);
    wr(IDX_LATCH, 32'h2);
    repeat (2 * (p + 1)) @(posedge clk_i);
    rdc("latch_clr", IDX_LATCH, 32'h0);
    pwm_check(w2, 1'b1);
    end_test("release");
    // Plain timer mode keeps every output low
    wr(IDX_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
    pwm_check(w2, 1'b0);
    end_test("timer_mode");
    report_and_stop();
  end
endmodule
